// ===== i2c_host_pkg.sv
package i2c_host_pkg;

    localparam int REG_W = 8;

    // device register map as seen from the controller
    localparam logic [1:0] REG_CTRL_A = 2'h0;
    localparam logic [1:0] REG_CTRL_B = 2'h1;
    localparam logic [1:0] REG_DATA = 2'h2;
    localparam logic [1:0] REG_STATUS = 2'h3;

    // bus_control_reg_b and bus_status_reg_b bit positions
    localparam int MASTER_SELECT_BIT = 7;
    localparam int TRANSMITTER_SELECT_BIT = 6;
    localparam int BUS_BUSY_BIT = 5;
    localparam int PIN_BIT = 4;
    localparam int ARBITRATION_LOST_BIT = 3;
    localparam int ADDRESS_MATCHED_BIT = 2;
    localparam int GENERAL_CALL_BIT = 1;
    localparam int LAST_RECEIVED_BIT = 0;

    // bus_control_reg_b write values
    localparam logic [7:0] CTRL_START = 8'hF0;
    localparam logic [7:0] CTRL_STOP = 8'hD0;
    localparam logic [7:0] CTRL_RESTART = 8'h10;
    localparam logic [7:0] CTRL_RELEASE = 8'h10;

    // bit_count_field and acknowledge enable in control register a
    localparam int BIT_COUNT_LSB = 5;
    localparam int ACK_ENABLE_BIT = 4;

    // restart setup time, counted on the link clock
    localparam int SETUP_NS = 4700;
    localparam int LINK_PERIOD_NS = 160;
    localparam int SETUP_CYC_INT = (SETUP_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    localparam int SETUP_W = 6;
    localparam logic [SETUP_W-1:0] SETUP_CYC = SETUP_W'(SETUP_CYC_INT);

    typedef enum logic [1:0] {
        OP_START = 2'h0,
        OP_STOP = 2'h1,
        OP_RESTART = 2'h2,
        OP_SERVICE = 2'h3
    } op_t;

    typedef enum logic [2:0] {
        ACT_NONE = 3'h0,
        ACT_TX = 3'h1,
        ACT_RELEASE = 3'h2,
        ACT_ADDR_ACK = 3'h3,
        ACT_AL_CLEAR = 3'h4,
        ACT_RX = 3'h5
    } action_t;

    // gray codes along the usual walk
    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_ST_RD = 4'h1,
        S_ST_WAIT = 4'h3,
        S_ST_CAP = 4'h2,
        S_WR_BC = 4'h6,
        S_WR_DATA = 4'h7,
        S_WR_CTRL = 4'h5,
        S_RD_DATA = 4'h4,
        S_RD_WAIT = 4'hC,
        S_RD_CAP = 4'hD,
        S_POLL_RD = 4'hF,
        S_POLL_WAIT = 4'hE,
        S_POLL_CAP = 4'hA,
        S_SETUP = 4'hB,
        S_DONE = 4'h9
    } state_t;

    typedef struct packed {
        op_t op;
        logic [7:0] data;
        logic [2:0] bitCount;
        logic masterRx;
    } cmd_t;

    typedef struct packed {
        logic isEvent;
        logic err;
        logic [7:0] status;
        logic [7:0] data;
    } result_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [1:0] addr;
        logic [7:0] wdata;
    } regAccess_t;

    // slave-mode handling chosen from a status byte
    function automatic action_t serviceAction(input logic [7:0] st);
        action_t act;
        act = ACT_NONE;
        if (!st[MASTER_SELECT_BIT])
        begin
            if (st[TRANSMITTER_SELECT_BIT])
            begin
                if (st[ADDRESS_MATCHED_BIT] || !st[LAST_RECEIVED_BIT])
                    act = ACT_TX;
                else
                    act = ACT_RELEASE;
            end
            else if (st[ADDRESS_MATCHED_BIT])
                act = ACT_ADDR_ACK;
            else if (st[ARBITRATION_LOST_BIT])
                act = ACT_AL_CLEAR;
            else
                act = ACT_RX;
        end
        return act;
    endfunction

endpackage

// ===== toggle_handshake.sv
`timescale 1ns/1ps
module toggle_handshake #(
    parameter int W = 8
) (
    // shared
    input wire logic reset,
    // source side
    input wire logic srcClk,
    input wire logic srcCe,
    input wire logic srcValid,
    input wire logic [W-1:0] srcData,
    output logic srcReady_r,
    // destination side
    input wire logic dstClk,
    input wire logic dstCe,
    output logic dstValid_r,
    output logic [W-1:0] dstData_r
);
    logic reqTog_r, reqTogNxt;
    logic [W-1:0] hold_r, holdNxt;
    logic ackMeta_r, ackSync_r;
    logic srcReadyNxt;
    logic accept;
    logic reqMeta_r, reqSync_r;
    logic ackTog_r, ackTogNxt;
    logic dstValidNxt;
    logic [W-1:0] dstDataNxt;

    always_comb
    begin
        accept = srcValid && srcReady_r;
        reqTogNxt = reqTog_r ^ accept;
        holdNxt = accept ? srcData : hold_r;
        srcReadyNxt = (ackSync_r == reqTogNxt);
    end

    always_ff @(posedge srcClk or posedge reset)
    begin
        if (reset)
        begin
            reqTog_r <= 1'b0;
            hold_r <= '0;
            ackMeta_r <= 1'b0;
            ackSync_r <= 1'b0;
            srcReady_r <= 1'b1;
        end
        else if (srcCe)
        begin
            reqTog_r <= reqTogNxt;
            hold_r <= holdNxt;
            ackMeta_r <= ackTog_r;
            ackSync_r <= ackMeta_r;
            srcReady_r <= srcReadyNxt;
        end
    end

    // hold_r is stable from the toggle until the ack returns
    always_comb
    begin
        ackTogNxt = reqSync_r;
        dstValidNxt = (reqSync_r != ackTog_r);
        dstDataNxt = dstValidNxt ? hold_r : dstData_r;
    end

    always_ff @(posedge dstClk or posedge reset)
    begin
        if (reset)
        begin
            reqMeta_r <= 1'b0;
            reqSync_r <= 1'b0;
            ackTog_r <= 1'b0;
            dstValid_r <= 1'b0;
            dstData_r <= '0;
        end
        else if (dstCe)
        begin
            reqMeta_r <= reqTog_r;
            reqSync_r <= reqMeta_r;
            ackTog_r <= ackTogNxt;
            dstValid_r <= dstValidNxt;
            dstData_r <= dstDataNxt;
        end
    end
endmodule // toggle_handshake

// ===== i2c_slave_stop_restart_control.sv
`timescale 1ns/1ps
module i2c_slave_stop_restart_control (
    // system
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // link side clock
    input wire logic linkClk,
    // user commands
    input wire logic cmdValid,
    input wire i2c_host_pkg::cmd_t cmd,
    output logic cmdReady,
    // user results and events
    output logic resValid,
    output i2c_host_pkg::result_t result,
    // device register port
    output i2c_host_pkg::regAccess_t devAcc,
    input wire logic [7:0] devRdata,
    input wire logic busInterrupt,
    input wire logic sclPin
);
    logic ceMeta_r, ceSync_r, linkCe;
    logic intMeta_r, intSync_r, intPrev_r;
    logic sclMeta_r, sclSync_r;
    logic cmdPulse;
    i2c_host_pkg::cmd_t cmdLink;
    logic resSend;
    logic resReady;
    i2c_host_pkg::result_t resLink;

    i2c_host_pkg::state_t state_r, stateNxt;
    i2c_host_pkg::cmd_t cur_r, curNxt;
    i2c_host_pkg::regAccess_t acc_r, accNxt;
    logic [7:0] status_r, statusNxt;
    logic [7:0] rxData_r, rxDataNxt;
    logic isEvent_r, isEventNxt;
    logic err_r, errNxt;
    logic phase_r, phaseNxt;
    logic intPend_r, intPendNxt;
    logic [i2c_host_pkg::SETUP_W-1:0] setupCnt_r, setupCntNxt;
    i2c_host_pkg::action_t act_r, actNxt;
    i2c_host_pkg::action_t decided;
    logic pollDone;

    toggle_handshake #(.W($bits(i2c_host_pkg::cmd_t))) cmdCross (
        .reset(reset),
        .srcClk(clk),
        .srcCe(ce),
        .srcValid(cmdValid),
        .srcData(cmd),
        .srcReady_r(cmdReady),
        .dstClk(linkClk),
        .dstCe(linkCe),
        .dstValid_r(cmdPulse),
        .dstData_r(cmdLink)
    );

    toggle_handshake #(.W($bits(i2c_host_pkg::result_t))) resCross (
        .reset(reset),
        .srcClk(linkClk),
        .srcCe(linkCe),
        .srcValid(resSend),
        .srcData(resLink),
        .srcReady_r(resReady),
        .dstClk(clk),
        .dstCe(ce),
        .dstValid_r(resValid),
        .dstData_r(result)
    );

    // pins and the enable enter the link domain through two flops each
    always_ff @(posedge linkClk or posedge reset)
    begin
        if (reset)
        begin
            ceMeta_r <= 1'b0;
            ceSync_r <= 1'b0;
            intMeta_r <= 1'b0;
            intSync_r <= 1'b0;
            sclMeta_r <= 1'b0;
            sclSync_r <= 1'b0;
        end
        else
        begin
            ceMeta_r <= ce;
            ceSync_r <= ceMeta_r;
            intMeta_r <= busInterrupt;
            intSync_r <= intMeta_r;
            sclMeta_r <= sclPin;
            sclSync_r <= sclMeta_r;
        end
    end

    assign linkCe = ceSync_r;
    assign devAcc = acc_r;
    assign decided = i2c_host_pkg::serviceAction(devRdata);
    assign resSend = (state_r == i2c_host_pkg::S_DONE);
    assign resLink = '{isEvent: isEvent_r, err: err_r, status: status_r, data: rxData_r};

    // restart needs bus free; after master receive the last bit is already one
    always_comb
    begin
        if (cur_r.masterRx)
            pollDone = !devRdata[i2c_host_pkg::BUS_BUSY_BIT] && sclSync_r;
        else
            pollDone = !devRdata[i2c_host_pkg::BUS_BUSY_BIT]
                && devRdata[i2c_host_pkg::LAST_RECEIVED_BIT];
    end

    always_comb
    begin
        stateNxt = state_r;
        curNxt = cur_r;
        accNxt = '0;
        statusNxt = status_r;
        rxDataNxt = rxData_r;
        isEventNxt = isEvent_r;
        errNxt = err_r;
        phaseNxt = phase_r;
        actNxt = act_r;
        setupCntNxt = setupCnt_r;
        // a new edge outranks the take-over clear
        intPendNxt = intPend_r;
        if (intSync_r && !intPrev_r)
            intPendNxt = 1'b1;
        unique case (state_r)
            i2c_host_pkg::S_IDLE:
            begin
                phaseNxt = 1'b0;
                errNxt = 1'b0;
                if (cmdPulse)
                begin
                    curNxt = cmdLink;
                    isEventNxt = 1'b0;
                    if (cmdLink.op == i2c_host_pkg::OP_RESTART)
                        stateNxt = i2c_host_pkg::S_WR_CTRL;
                    else
                        stateNxt = i2c_host_pkg::S_ST_RD;
                end
                else if (intPend_r)
                begin
                    intPendNxt = intSync_r && !intPrev_r;
                    isEventNxt = 1'b1;
                    stateNxt = i2c_host_pkg::S_ST_RD;
                end
            end
            i2c_host_pkg::S_ST_RD:
            begin
                accNxt = '{rd: 1'b1, wr: 1'b0, addr: i2c_host_pkg::REG_STATUS, wdata: 8'h00};
                stateNxt = i2c_host_pkg::S_ST_WAIT;
            end
            i2c_host_pkg::S_ST_WAIT:
                stateNxt = i2c_host_pkg::S_ST_CAP;
            i2c_host_pkg::S_ST_CAP:
            begin
                statusNxt = devRdata;
                actNxt = decided;
                if (isEvent_r)
                    stateNxt = i2c_host_pkg::S_DONE;
                else
                begin
                    unique case (cur_r.op)
                        i2c_host_pkg::OP_START:
                        begin
                            errNxt = devRdata[i2c_host_pkg::BUS_BUSY_BIT];
                            stateNxt = errNxt ? i2c_host_pkg::S_DONE : i2c_host_pkg::S_WR_DATA;
                        end
                        i2c_host_pkg::OP_STOP:
                        begin
                            errNxt = !devRdata[i2c_host_pkg::BUS_BUSY_BIT];
                            stateNxt = errNxt ? i2c_host_pkg::S_DONE : i2c_host_pkg::S_WR_CTRL;
                        end
                        i2c_host_pkg::OP_SERVICE:
                        begin
                            unique case (decided)
                                i2c_host_pkg::ACT_TX, i2c_host_pkg::ACT_RX:
                                    stateNxt = i2c_host_pkg::S_WR_BC;
                                i2c_host_pkg::ACT_RELEASE:
                                    stateNxt = i2c_host_pkg::S_WR_CTRL;
                                i2c_host_pkg::ACT_ADDR_ACK, i2c_host_pkg::ACT_AL_CLEAR:
                                    stateNxt = i2c_host_pkg::S_RD_DATA;
                                default:
                                begin
                                    errNxt = 1'b1;
                                    stateNxt = i2c_host_pkg::S_DONE;
                                end
                            endcase
                        end
                        default:
                            stateNxt = i2c_host_pkg::S_DONE;
                    endcase
                end
            end
            i2c_host_pkg::S_WR_BC:
            begin
                accNxt = '{rd: 1'b0, wr: 1'b1, addr: i2c_host_pkg::REG_CTRL_A,
                    wdata: 8'(({5'h00, cur_r.bitCount} << i2c_host_pkg::BIT_COUNT_LSB)
                    | (8'h01 << i2c_host_pkg::ACK_ENABLE_BIT))};
                if (act_r == i2c_host_pkg::ACT_TX)
                    stateNxt = i2c_host_pkg::S_WR_DATA;
                else
                    stateNxt = i2c_host_pkg::S_RD_DATA;
            end
            i2c_host_pkg::S_WR_DATA:
            begin
                // the buffer write also frees the held clock line
                accNxt = '{rd: 1'b0, wr: 1'b1, addr: i2c_host_pkg::REG_DATA,
                    wdata: cur_r.data};
                if (cur_r.op == i2c_host_pkg::OP_SERVICE)
                    stateNxt = i2c_host_pkg::S_DONE;
                else
                    stateNxt = i2c_host_pkg::S_WR_CTRL;
            end
            i2c_host_pkg::S_WR_CTRL:
            begin
                accNxt.wr = 1'b1;
                accNxt.addr = i2c_host_pkg::REG_CTRL_B;
                stateNxt = i2c_host_pkg::S_DONE;
                unique case (cur_r.op)
                    i2c_host_pkg::OP_STOP:
                    begin
                        accNxt.wdata = i2c_host_pkg::CTRL_STOP;
                        stateNxt = i2c_host_pkg::S_POLL_RD;
                    end
                    i2c_host_pkg::OP_RESTART:
                    begin
                        if (phase_r)
                            accNxt.wdata = i2c_host_pkg::CTRL_START;
                        else
                        begin
                            accNxt.wdata = i2c_host_pkg::CTRL_RESTART;
                            stateNxt = i2c_host_pkg::S_POLL_RD;
                        end
                    end
                    i2c_host_pkg::OP_SERVICE:
                        accNxt.wdata = i2c_host_pkg::CTRL_RELEASE;
                    default:
                        accNxt.wdata = i2c_host_pkg::CTRL_START;
                endcase
            end
            i2c_host_pkg::S_RD_DATA:
            begin
                accNxt = '{rd: 1'b1, wr: 1'b0, addr: i2c_host_pkg::REG_DATA, wdata: 8'h00};
                stateNxt = i2c_host_pkg::S_RD_WAIT;
            end
            i2c_host_pkg::S_RD_WAIT:
                stateNxt = i2c_host_pkg::S_RD_CAP;
            i2c_host_pkg::S_RD_CAP:
            begin
                rxDataNxt = devRdata;
                stateNxt = i2c_host_pkg::S_DONE;
            end
            i2c_host_pkg::S_POLL_RD:
            begin
                // only status reads while the stop or restart settles
                accNxt = '{rd: 1'b1, wr: 1'b0, addr: i2c_host_pkg::REG_STATUS, wdata: 8'h00};
                stateNxt = i2c_host_pkg::S_POLL_WAIT;
            end
            i2c_host_pkg::S_POLL_WAIT:
                stateNxt = i2c_host_pkg::S_POLL_CAP;
            i2c_host_pkg::S_POLL_CAP:
            begin
                statusNxt = devRdata;
                stateNxt = i2c_host_pkg::S_POLL_RD;
                if (cur_r.op == i2c_host_pkg::OP_STOP)
                begin
                    if (!devRdata[i2c_host_pkg::BUS_BUSY_BIT])
                        stateNxt = i2c_host_pkg::S_DONE;
                end
                else if (pollDone)
                begin
                    setupCntNxt = i2c_host_pkg::SETUP_CYC;
                    stateNxt = i2c_host_pkg::S_SETUP;
                end
            end
            i2c_host_pkg::S_SETUP:
            begin
                setupCntNxt = setupCnt_r - 1'b1;
                if (setupCnt_r == 1)
                begin
                    phaseNxt = 1'b1;
                    stateNxt = i2c_host_pkg::S_WR_DATA;
                end
            end
            i2c_host_pkg::S_DONE:
                if (resReady)
                    stateNxt = i2c_host_pkg::S_IDLE;
            default:
                stateNxt = i2c_host_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge linkClk or posedge reset)
    begin
        if (reset)
        begin
            state_r <= i2c_host_pkg::S_IDLE;
            cur_r <= '0;
            acc_r <= '0;
            status_r <= 8'h00;
            rxData_r <= 8'h00;
            isEvent_r <= 1'b0;
            err_r <= 1'b0;
            phase_r <= 1'b0;
            act_r <= i2c_host_pkg::ACT_NONE;
            setupCnt_r <= '0;
            intPend_r <= 1'b0;
            intPrev_r <= 1'b0;
        end
        else if (linkCe)
        begin
            state_r <= stateNxt;
            cur_r <= curNxt;
            acc_r <= accNxt;
            status_r <= statusNxt;
            rxData_r <= rxDataNxt;
            isEvent_r <= isEventNxt;
            err_r <= errNxt;
            phase_r <= phaseNxt;
            act_r <= actNxt;
            setupCnt_r <= setupCntNxt;
            intPend_r <= intPendNxt;
            intPrev_r <= intSync_r;
        end
    end

    default clocking cb @(posedge linkClk); endclocking
    default disable iff (reset);

    logic svcCap;
    assign svcCap = (state_r == i2c_host_pkg::S_ST_CAP) && !isEvent_r && linkCe
        && (cur_r.op == i2c_host_pkg::OP_SERVICE);

    startAfterData_a: assert property (acc_r.wr && acc_r.addr == i2c_host_pkg::REG_CTRL_B
        && acc_r.wdata == i2c_host_pkg::CTRL_START |-> $past(acc_r.wr)
        && $past(acc_r.addr) == i2c_host_pkg::REG_DATA)
        else $error("start written without address in buffer");
    stopWhenBusy_a: assert property (acc_r.wr && acc_r.addr == i2c_host_pkg::REG_CTRL_B
        && cur_r.op == i2c_host_pkg::OP_STOP |-> status_r[i2c_host_pkg::BUS_BUSY_BIT])
        else $error("stop written while bus not busy");
    stopHands_a: assert property (acc_r.wr && cur_r.op == i2c_host_pkg::OP_STOP
        |=> (!acc_r.wr)[*8])
        else $error("register written before stop appeared");
    restartPoll_a: assert property (state_r == i2c_host_pkg::S_SETUP
        && $past(state_r) == i2c_host_pkg::S_POLL_CAP && !cur_r.masterRx
        |-> !status_r[i2c_host_pkg::BUS_BUSY_BIT]
        && status_r[i2c_host_pkg::LAST_RECEIVED_BIT])
        else $error("restart left poll with bus not free");
    setupTime_a: assert property (state_r == i2c_host_pkg::S_SETUP
        && $past(state_r) == i2c_host_pkg::S_POLL_CAP && linkCe
        |-> setupCnt_r == i2c_host_pkg::SETUP_CYC)
        else $error("setup wait not loaded with full time");
    slaveTx_a: assert property (svcCap && decided == i2c_host_pkg::ACT_TX
        |-> ##2 (acc_r.wr && acc_r.addr == i2c_host_pkg::REG_CTRL_A)
        ##1 (acc_r.wr && acc_r.addr == i2c_host_pkg::REG_DATA))
        else $error("slave transmit not loaded");
    releaseLrb_a: assert property (svcCap && decided == i2c_host_pkg::ACT_RELEASE
        |-> ##2 (acc_r.wr && acc_r.addr == i2c_host_pkg::REG_CTRL_B
        && acc_r.wdata == i2c_host_pkg::CTRL_RELEASE))
        else $error("bus not released after nack");
    dummyRead_a: assert property (svcCap && (decided == i2c_host_pkg::ACT_ADDR_ACK
        || decided == i2c_host_pkg::ACT_AL_CLEAR)
        |-> ##2 (acc_r.rd && acc_r.addr == i2c_host_pkg::REG_DATA))
        else $error("buffer not read to acknowledge address");
    rxRead_a: assert property (svcCap && decided == i2c_host_pkg::ACT_RX
        |-> ##2 (acc_r.wr && acc_r.addr == i2c_host_pkg::REG_CTRL_A)
        ##1 (acc_r.rd && acc_r.addr == i2c_host_pkg::REG_DATA))
        else $error("received word not read");
    rxPinCheck_a: assert property (state_r == i2c_host_pkg::S_SETUP
        && $past(state_r) == i2c_host_pkg::S_POLL_CAP && cur_r.masterRx
        |-> $past(sclSync_r))
        else $error("restart after receive ignored clock pin");

    stopSeen_c: cover property (state_r == i2c_host_pkg::S_POLL_CAP
        && cur_r.op == i2c_host_pkg::OP_STOP ##1 state_r == i2c_host_pkg::S_DONE);
    restartDone_c: cover property (state_r == i2c_host_pkg::S_SETUP
        ##[1:100] (acc_r.wr && acc_r.wdata == i2c_host_pkg::CTRL_START));
    slaveRx_c: cover property (svcCap && decided == i2c_host_pkg::ACT_RX);
    eventSent_c: cover property (resSend && isEvent_r && resReady);
endmodule // i2c_slave_stop_restart_control

// ===== i2c_dev_model.sv
`timescale 1ns/1ps
module i2c_dev_model (
    // link side
    input wire logic linkClk,
    input wire logic reset,
    input wire i2c_host_pkg::regAccess_t devAcc,
    output logic [7:0] devRdata,
    // bench control
    input wire logic ld,
    input wire logic [7:0] stIn,
    output logic [7:0] ctrlB_r
);
    logic [7:0] stat_r;
    always_ff @(posedge linkClk or posedge reset)
    begin
        if (reset)
        begin
            stat_r <= 8'h00;
            ctrlB_r <= 8'h00;
            devRdata <= 8'h00;
        end
        else if (ld)
        begin
            stat_r <= stIn;
            ctrlB_r <= 8'h00;
        end
        else
        begin
            // read data lives one cycle only
            devRdata <= ~devRdata;
            if (devAcc.rd)
                devRdata <= (devAcc.addr == 2'h3) ? stat_r : 8'h5A;
            if ((devAcc.rd || devAcc.wr) && devAcc.addr == 2'h2)
                stat_r[3] <= 1'h0;
            if (devAcc.wr && devAcc.addr == 2'h1)
            begin
                ctrlB_r <= devAcc.wdata;
                stat_r[5] <= devAcc.wdata[5];
                stat_r[0] <= stat_r[0] | ~devAcc.wdata[7];
            end
        end
    end
endmodule // i2c_dev_model

// ===== test_i2c_slave_stop_restart_control.sv
`timescale 1ns/1ps
module test_i2c_slave_stop_restart_control;
    typedef struct packed {logic [1:0] op; logic [7:0] st; logic err; logic [7:0] cb;
        logic [8:0] d;} row_t;
    logic clk, linkClk, reset, cmdValid, cmdReady, resValid, ld, irq, scl;
    logic [7:0] devRdata, st, ctrlB;
    i2c_host_pkg::cmd_t cmd;
    i2c_host_pkg::result_t result;
    i2c_host_pkg::regAccess_t devAcc;
    int n_fail = 0;
    int tests_run = 0;
    row_t rows [11] = '{
        '{2'h0, 8'h00, 1'h0, 8'hF0, 9'h000}, '{2'h0, 8'h20, 1'h1, 8'h00, 9'h000},
        '{2'h1, 8'h20, 1'h0, 8'hD0, 9'h000}, '{2'h1, 8'h00, 1'h1, 8'h00, 9'h000},
        '{2'h2, 8'h20, 1'h0, 8'hF0, 9'h000}, '{2'h3, 8'h44, 1'h0, 8'h00, 9'h000},
        '{2'h3, 8'h41, 1'h0, 8'h10, 9'h000}, '{2'h3, 8'h00, 1'h0, 8'h00, 9'h15A},
        '{2'h3, 8'h80, 1'h1, 8'h00, 9'h000}, '{2'h3, 8'h04, 1'h0, 8'h00, 9'h15A},
        '{2'h3, 8'h08, 1'h0, 8'h00, 9'h15A}};
    i2c_slave_stop_restart_control i2c_slave_stop_restart_control_inst (.clk(clk),
        .reset(reset), .ce(1'h1), .linkClk(linkClk), .cmdValid(cmdValid), .cmd(cmd),
        .cmdReady(cmdReady), .resValid(resValid), .result(result), .devAcc(devAcc),
        .devRdata(devRdata), .busInterrupt(irq), .sclPin(scl));
    i2c_dev_model i2c_dev_model_inst (.linkClk(linkClk), .reset(reset), .devAcc(devAcc),
        .devRdata(devRdata), .ld(ld), .stIn(st), .ctrlB_r(ctrlB));
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic load(input logic [7:0] s);
        st = s;
        ld = 1'h1;
        repeat (40) @(posedge clk);
        #1 ld = 1'h0;
        repeat (40) @(posedge clk);
    endtask
    // look just after each edge so the one-cycle pulse is seen settled
    task automatic waitRes();
        repeat (5000)
            if (resValid !== 1'h1)
            begin
                @(posedge clk);
                #1;
            end
        if (resValid !== 1'h1)
        begin
            n_fail++;
            test_done();
        end
    endtask
    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        linkClk = 1'h0;
        #37;
        forever #80 linkClk = ~linkClk;
    end
    initial
    begin
        #900000;
        n_fail++;
        test_done();
    end
    initial
    begin
        reset = 1'h0;
        cmdValid = 1'h0;
        ld = 1'h0;
        irq = 1'h0;
        st = 8'h00;
        cmd = '0;
        scl = 1'h1;
        // a clean rising edge: no link edge falls inside the reset pulse
        #1 reset = 1'h1;
        repeat (6) @(posedge clk);
        #1 reset = 1'h0;
        chk(9'({cmdReady, resValid, devAcc.rd, devAcc.wr}), 9'h008);
        foreach (rows[i])
        begin
            load(rows[i].st);
            #1 cmd = '{i2c_host_pkg::op_t'(rows[i].op), 8'hA5, 3'h0, 1'h0};
            cmdValid = 1'h1;
            @(posedge clk);
            #1 cmdValid = 1'h0;
            waitRes();
            chk(9'(result.err), 9'(rows[i].err));
            chk(9'(ctrlB), 9'(rows[i].cb));
            if (rows[i].d[8])
                chk({1'h1, result.data}, rows[i].d);
        end
        load(8'h44);
        #1 irq = 1'h1;
        waitRes();
        chk({result.isEvent, result.status}, 9'h144);
        irq = 1'h0;
        // restart after master receive: clock pin low keeps it polling
        scl = 1'h0;
        load(8'h20);
        #1 cmd = '{i2c_host_pkg::OP_RESTART, 8'hA5, 3'h0, 1'h1};
        cmdValid = 1'h1;
        @(posedge clk);
        #1 cmdValid = 1'h0;
        repeat (300) @(posedge clk);
        #1 chk({result.isEvent, ctrlB}, 9'h110);
        scl = 1'h1;
        waitRes();
        chk({result.isEvent, ctrlB}, 9'h0F0);
        chk(9'(result.err), 9'h000);
        test_done();
    end
endmodule // test_i2c_slave_stop_restart_control
